// file: cdsc_defs.svh
// constants for the check diagnostic status capture block
`ifndef CDSC_DEFS_SVH
`define CDSC_DEFS_SVH

// diagnostic bit n counts from 1 at the msb of the 32-bit word
`define CDSC_POS(n) (32 - (n))

// parity word flags and copied fields (diagnostic bit numbers)
`define CDSC_P_CS_TYPE1       1
`define CDSC_P_CS_TYPE2       2
`define CDSC_P_BURST          3
`define CDSC_P_DMX_DIR        4
`define CDSC_P_CODE_HI        5
`define CDSC_P_CODE_LO        7
`define CDSC_P_CUM            8
`define CDSC_P_ECC_READ       9
`define CDSC_P_PREFETCH       10
`define CDSC_P_ADDR_IN        11
`define CDSC_P_RDX            12
`define CDSC_P_REGFILE        13
`define CDSC_P_REG_ADDR       14
`define CDSC_P_DMX_CYCLE      15
`define CDSC_P_AP_BOARD       16
`define CDSC_P_C_BOARD        17
`define CDSC_P_MDB_EVEN       18
`define CDSC_P_MDB_ODD        19
`define CDSC_P_MISS_MODULE    20
`define CDSC_P_MAB            21
`define CDSC_P_MAR_INC        22
`define CDSC_P_MA15           23
`define CDSC_P_MA16           24
`define CDSC_P_MISS_ECC_UNCORRECTABLE_FLAG      25
`define CDSC_P_MISS_ECCC      26
`define CDSC_P_CACHE_INDEX    27
`define CDSC_P_CACHE_ODD      28
`define CDSC_P_CACHE_EVEN     29
`define CDSC_P_CACHE_EXEC     30
`define CDSC_P_UNUSED_HI      31
`define CDSC_P_UNUSED_LO      32

// status word fields (diagnostic bit numbers)
`define CDSC_S_IMMEDIATE      1
`define CDSC_S_MACHINE        2
`define CDSC_S_MEM_PARITY     3
`define CDSC_S_MISSING        4
`define CDSC_S_MC_HI          5
`define CDSC_S_MC_LO          7
`define CDSC_S_CUM_OK         8
`define CDSC_S_ECC_UNCORRECTABLE_FLAG           9
`define CDSC_S_ECCC           10
`define CDSC_S_BACKUP_COUNT_INVALID           11
`define CDSC_S_BACKUP_HI      12
`define CDSC_S_BACKUP_LO      14
`define CDSC_S_DMX            15
`define CDSC_S_IO             16
`define CDSC_S_SYND_HI        17
`define CDSC_S_SYND_LO        22
`define CDSC_S_UNUSED         23
`define CDSC_S_MODULE         24
`define CDSC_S_RMA_INV        25
`define CDSC_S_UV_PASS        26
`define CDSC_S_UV_TEST_HI     27
`define CDSC_S_UV_TEST_LO     32

// register map, byte addresses on the lite bus
`define CDSC_AW               12
`define CDSC_A_PARITY         12'h000
`define CDSC_A_STATUS         12'h004
`define CDSC_A_CTRL           12'h008
`define CDSC_CTRL_EN          0
`define CDSC_CTRL_RELEASE     1
`define CDSC_CTRL_HELD        8
`define CDSC_CTRL_EN_RST      1'h1
`define CDSC_RESP_OKAY        2'h0
`define CDSC_RESP_SLVERR      2'h2
`define CDSC_ZERO32           32'h0000_0000

// synchronised input vector: check line, parity raw, status raw
`define CDSC_SYNC_W           65
`define CDSC_SYNC_CHK         64

`endif

// file: cdsc_pkg.sv
// types of the check diagnostic status capture block
`include "cdsc_defs.svh"
package cdsc_pkg;

  // whole state of the capture top, registered in one process
  typedef struct packed {
    logic [31:0]           par_acc;
    logic [31:0]           par_cap;
    logic [31:0]           st_cap;
    logic                  held;
    logic                  rd_par;
    logic                  rd_st;
    logic                  chk_d;
    logic                  cap_en;
    logic                  awready;
    logic                  wready;
    logic                  aw_have;
    logic                  w_have;
    logic [`CDSC_AW-1:0]   aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
  } cdsc_state_s;

endpackage

// file: cdsc_sync.sv
// two-flop synchroniser bank for the error and check input pins
`timescale 1ns/1ps
`include "cdsc_defs.svh"
module cdsc_sync #(
  parameter int W = `CDSC_SYNC_W
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cdsc_sync_s;

  cdsc_sync_s st_ff;
  cdsc_sync_s nxt_st;

  // per bit: first stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      nxt_st.s1[i] = async_in[i];
      nxt_st.s2[i] = st_ff.s1[i];
    end
  end

  // synchronous reset clears both stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.s2;

endmodule

// file: cdsc_capture.sv
// check diagnostic status capture with an axi4-lite register slave
`timescale 1ns/1ps
`include "cdsc_defs.svh"
module cdsc_capture (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // axi4-lite write address
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [`CDSC_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  // axi4-lite write data
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  // axi4-lite write response
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  // axi4-lite read address
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [`CDSC_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  // axi4-lite read data
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  // check request line, rising edge captures both words unless an earlier capture is still held
  input  wire logic                check_raise,
  // other parity sources
  input  wire logic                cs_parity_type1,
  input  wire logic                cs_parity_type2,
  input  wire logic                burst_dmx_parity,
  input  wire logic                dmx_output_dir,
  input  wire logic [2:0]          board_parity_code,
  input  wire logic                control_unit_memory_parity,
  input  wire logic                ecc_read_uncorrectable,
  input  wire logic                prefetch_board_parity,
  input  wire logic                addr_input_parity,
  input  wire logic                rdx_parity,
  input  wire logic                register_file_parity,
  input  wire logic                register_addr_parity,
  // board, bus and cache-miss parity sources
  input  wire logic                direct_memory_transfer_parity,
  input  wire logic                address_board_unit_parity,
  input  wire logic                c_board_parity,
  input  wire logic                memory_data_bus_even_parity,
  input  wire logic                memory_data_bus_odd_parity,
  input  wire logic                miss_missing_module,
  input  wire logic                memory_address_bus_parity,
  input  wire logic                memory_address_register_incr,
  input  wire logic                mem_addr_bit15_indicator,
  input  wire logic                mem_addr_bit16_indicator,
  input  wire logic                miss_ecc_uncorrectable,
  input  wire logic                miss_ecc_correctable,
  // cache read parity sources
  input  wire logic                cache_index_parity,
  input  wire logic                cache_data_odd_parity,
  input  wire logic                cache_data_even_parity,
  input  wire logic                cache_cycle_execute,
  // check status sources
  input  wire logic                check_immediate,
  input  wire logic                machine_check,
  input  wire logic                memory_parity_check,
  input  wire logic                missing_module_check,
  input  wire logic [2:0]          machine_check_code,
  input  wire logic                control_unit_memory_error,
  input  wire logic                ecc_uncorrectable_flag,
  input  wire logic                ecc_correctable_flag,
  input  wire logic                backup_count_invalid,
  input  wire logic [2:0]          pc_backup_count,
  input  wire logic                dmx_in_progress,
  input  wire logic                io_in_progress,
  input  wire logic [5:0]          ecc_syndrome,
  input  wire logic                error_addr_bit15,
  input  wire logic                error_address_invalid,
  input  wire logic                uverify_pass,
  input  wire logic [5:0]          uverify_test,
  // capture state for the check handler
  output logic                     diag_held
);

  ////////////////////////////////////////////////////////////////////////
  // raw pin words, assembled in diagnostic bit order before syncing
  logic [31:0]             raw_par;
  logic [31:0]             raw_st;
  logic [`CDSC_SYNC_W-1:0] s_vec;
  logic [31:0]             sp;
  logic [31:0]             sst;
  logic                    s_chk;

  // parity word layout, unused tail tied low
  assign raw_par = {cs_parity_type1, cs_parity_type2, burst_dmx_parity,
                    dmx_output_dir, board_parity_code,
                    control_unit_memory_parity, ecc_read_uncorrectable,
                    prefetch_board_parity, addr_input_parity, rdx_parity,
                    register_file_parity, register_addr_parity,
                    direct_memory_transfer_parity,
                    address_board_unit_parity, c_board_parity,
                    memory_data_bus_even_parity, memory_data_bus_odd_parity,
                    miss_missing_module, memory_address_bus_parity,
                    memory_address_register_incr, mem_addr_bit15_indicator,
                    mem_addr_bit16_indicator, miss_ecc_uncorrectable,
                    miss_ecc_correctable, cache_index_parity,
                    cache_data_odd_parity, cache_data_even_parity,
                    cache_cycle_execute, 2'h0};

  // status word layout; bit 8 reads low while control memory is in error
  assign raw_st = {check_immediate, machine_check, memory_parity_check,
                   missing_module_check, machine_check_code,
                   ~control_unit_memory_error, ecc_uncorrectable_flag,
                   ecc_correctable_flag, backup_count_invalid,
                   pc_backup_count, dmx_in_progress, io_in_progress,
                   ecc_syndrome, 1'h0, error_addr_bit15,
                   error_address_invalid, uverify_pass, uverify_test};

  // every check and error pin crosses two flops before any logic reads it, bar the inverter on control_unit_memory_error
  cdsc_sync #(
    .W (`CDSC_SYNC_W)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({check_raise, raw_par, raw_st}),
    .sync_out (s_vec)
  );

  assign s_chk = s_vec[`CDSC_SYNC_CHK];
  assign sp    = s_vec[63:32];

  ////////////////////////////////////////////////////////////////////////
  // status word conditioning, taken whole at the check edge
  logic mem_err;

  assign mem_err = s_vec[`CDSC_POS(`CDSC_S_MEM_PARITY)] |
                   s_vec[`CDSC_POS(`CDSC_S_MISSING)];

  // qualifiers are only meaningful beside the memory parity flag, the module bit beside either memory check flag
  always_comb begin
    sst = s_vec[31:0];
    sst[`CDSC_POS(`CDSC_S_ECC_UNCORRECTABLE_FLAG)] = s_vec[`CDSC_POS(`CDSC_S_ECC_UNCORRECTABLE_FLAG)] &
      s_vec[`CDSC_POS(`CDSC_S_MEM_PARITY)];
    sst[`CDSC_POS(`CDSC_S_ECCC)] = s_vec[`CDSC_POS(`CDSC_S_ECCC)] &
      s_vec[`CDSC_POS(`CDSC_S_MEM_PARITY)];
    if (!s_vec[`CDSC_POS(`CDSC_S_MEM_PARITY)]) begin
      sst[`CDSC_POS(`CDSC_S_SYND_HI):`CDSC_POS(`CDSC_S_SYND_LO)] = '0;
    end
    sst[`CDSC_POS(`CDSC_S_UNUSED)] = 1'h0;
    sst[`CDSC_POS(`CDSC_S_MODULE)] =
      s_vec[`CDSC_POS(`CDSC_S_MODULE)] & mem_err;
  end

  ////////////////////////////////////////////////////////////////////////
  // parity word: sticky flags plus fields copied on their trigger
  logic [31:0] flag_mask;
  logic [31:0] copy_mask;
  logic [31:0] par_live;
  logic        miss_err;
  logic        cache_err;
  logic        board_err;
  logic        dmx_err;

  // copied fields are levels, everything else is a sticky flag
  always_comb begin
    copy_mask = '0;
    copy_mask[`CDSC_POS(`CDSC_P_DMX_DIR)] = 1'h1;
    copy_mask[`CDSC_POS(`CDSC_P_CODE_HI):`CDSC_POS(`CDSC_P_CODE_LO)] = '1;
    copy_mask[`CDSC_POS(`CDSC_P_MA15)] = 1'h1;
    copy_mask[`CDSC_POS(`CDSC_P_MA16)] = 1'h1;
    copy_mask[`CDSC_POS(`CDSC_P_CACHE_EXEC)] = 1'h1;
    flag_mask = ~copy_mask;
  end

  // triggers that decide when a copied field is refreshed
  assign miss_err  = sp[`CDSC_POS(`CDSC_P_MISS_MODULE)] |
                     sp[`CDSC_POS(`CDSC_P_MAB)] |
                     sp[`CDSC_POS(`CDSC_P_MISS_ECC_UNCORRECTABLE_FLAG)] |
                     sp[`CDSC_POS(`CDSC_P_MISS_ECCC)];
  assign cache_err = sp[`CDSC_POS(`CDSC_P_CACHE_INDEX)] |
                     sp[`CDSC_POS(`CDSC_P_CACHE_ODD)] |
                     sp[`CDSC_POS(`CDSC_P_CACHE_EVEN)];
  assign board_err = sp[`CDSC_POS(`CDSC_P_AP_BOARD)] |
                     sp[`CDSC_POS(`CDSC_P_C_BOARD)];
  assign dmx_err   = sp[`CDSC_POS(`CDSC_P_BURST)] |
                     sp[`CDSC_POS(`CDSC_P_DMX_CYCLE)];

  ////////////////////////////////////////////////////////////////////////
  // state register and next-state logic
  cdsc_pkg::cdsc_state_s st_ff;
  cdsc_pkg::cdsc_state_s nxt_st;

  logic aw_go;
  logic w_go;
  logic ar_go;
  logic release_now;
  logic cap_now;

  assign aw_go = s_axi_awvalid & st_ff.awready;
  assign w_go  = s_axi_wvalid & st_ff.wready;
  assign ar_go = s_axi_arvalid & st_ff.arready;
  // live parity word: stored flags, new events, refreshed copies
  always_comb begin
    par_live = (st_ff.par_acc & flag_mask) | (sp & flag_mask);
    par_live = par_live | (st_ff.par_acc & copy_mask);
    if (miss_err) begin
      par_live[`CDSC_POS(`CDSC_P_MA15)] = sp[`CDSC_POS(`CDSC_P_MA15)];
      par_live[`CDSC_POS(`CDSC_P_MA16)] = sp[`CDSC_POS(`CDSC_P_MA16)];
    end
    if (cache_err) begin
      par_live[`CDSC_POS(`CDSC_P_CACHE_EXEC)] =
        sp[`CDSC_POS(`CDSC_P_CACHE_EXEC)];
    end
    if (board_err) begin
      par_live[`CDSC_POS(`CDSC_P_CODE_HI):`CDSC_POS(`CDSC_P_CODE_LO)] =
        sp[`CDSC_POS(`CDSC_P_CODE_HI):`CDSC_POS(`CDSC_P_CODE_LO)];
    end
    if (dmx_err) begin
      par_live[`CDSC_POS(`CDSC_P_DMX_DIR)] = sp[`CDSC_POS(`CDSC_P_DMX_DIR)];
    end
    // unused tail never set
    par_live[`CDSC_POS(`CDSC_P_UNUSED_HI)] = 1'h0;
    par_live[`CDSC_POS(`CDSC_P_UNUSED_LO)] = 1'h0;
  end

  // main next-state process
  always_comb begin
    nxt_st = st_ff;
    release_now = 1'h0;
    // sticky flags keep accumulating until a capture takes them
    nxt_st.par_acc = par_live;
    nxt_st.chk_d   = s_chk;
    // write address and data are taken in either order
    if (aw_go) begin
      nxt_st.aw_have = 1'h1;
      nxt_st.awready = 1'h0;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (w_go) begin
      nxt_st.w_have = 1'h1;
      nxt_st.wready = 1'h0;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    // response once both halves are in
    if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid) begin
      nxt_st.bvalid  = 1'h1;
      nxt_st.aw_have = 1'h0;
      nxt_st.w_have  = 1'h0;
      nxt_st.bresp   = `CDSC_RESP_OKAY;
      if (st_ff.aw_addr == `CDSC_A_CTRL) begin
        if (st_ff.w_strb[0]) begin
          nxt_st.cap_en = st_ff.w_data[`CDSC_CTRL_EN];
          release_now   = st_ff.w_data[`CDSC_CTRL_RELEASE];
        end
      end else if (st_ff.aw_addr != `CDSC_A_PARITY &&
                   st_ff.aw_addr != `CDSC_A_STATUS) begin
        nxt_st.bresp = `CDSC_RESP_SLVERR;
      end
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid  = 1'h0;
      nxt_st.awready = 1'h1;
      nxt_st.wready  = 1'h1;
    end
    // read: data registered at the address handshake
    if (ar_go) begin
      nxt_st.arready = 1'h0;
      nxt_st.rvalid  = 1'h1;
      nxt_st.rresp   = `CDSC_RESP_OKAY;
      nxt_st.rdata   = `CDSC_ZERO32;
      case (s_axi_araddr)
        `CDSC_A_PARITY: begin
          nxt_st.rdata  = st_ff.par_cap;
          nxt_st.rd_par = st_ff.held;
        end
        `CDSC_A_STATUS: begin
          nxt_st.rdata = st_ff.st_cap;
          nxt_st.rd_st = st_ff.held;
        end
        `CDSC_A_CTRL: begin
          nxt_st.rdata[`CDSC_CTRL_EN]   = st_ff.cap_en;
          nxt_st.rdata[`CDSC_CTRL_HELD] = st_ff.held;
        end
        default: begin
          nxt_st.rresp = `CDSC_RESP_SLVERR;
        end
      endcase
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid  = 1'h0;
      nxt_st.arready = 1'h1;
    end
    // hold ends once the handler has read both words, or on release
    if (st_ff.held && st_ff.rd_par && st_ff.rd_st) begin
      release_now = 1'h1;
    end
    if (release_now) begin
      nxt_st.held   = 1'h0;
      nxt_st.rd_par = 1'h0;
      nxt_st.rd_st  = 1'h0;
    end
    // a check edge in the release cycle still captures: set beats clear
    cap_now = s_chk && !st_ff.chk_d && st_ff.cap_en &&
              (!st_ff.held || release_now);
    if (cap_now) begin
      nxt_st.par_cap = par_live;
      nxt_st.st_cap  = sst;
      nxt_st.par_acc = '0;
      nxt_st.held    = 1'h1;
      nxt_st.rd_par  = 1'h0;
      nxt_st.rd_st   = 1'h0;
    end
  end

  // synchronous reset to idle, capture enabled, words cleared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff         <= '0;
      st_ff.cap_en  <= `CDSC_CTRL_EN_RST;
      st_ff.awready <= 1'h1;
      st_ff.wready  <= 1'h1;
      st_ff.arready <= 1'h1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready  = st_ff.wready;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign diag_held     = st_ff.held;

endmodule

// file: cdsc_capture_chk.sv
// checker on the capture block handshakes and hold state
`timescale 1ns/1ps
module cdsc_capture_chk (
  // clock, reset and bus handshakes
  input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready,
  input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input wire logic        s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // capture request and hold
  input wire logic        check_raise, diag_held
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge, as the idle slave allows
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_resp_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer not two cycles after take");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after take");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready) else $error("read channel stuck");
  unmapped_err_a: assert property ((rd_take and s_axi_araddr > 12'h008)
    |=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");
  cap_cause_a: assert property (
    $rose(diag_held) |-> $past(check_raise, 2))
    else $error("capture without check request");
  held_keep_a: assert property (
    diag_held && s_axi_arready && s_axi_awready |=> diag_held)
    else $error("hold dropped with no access");
endmodule
bind cdsc_capture cdsc_capture_chk u_chk (.*);

// file: check_diag_status_capture_tb_top.sv
// self-checking bench for the check diagnostic capture block
`timescale 1ns/1ps
`include "cdsc_defs.svh"
module check_diag_status_capture_tb_top;
  logic        aclk, aresetn, check_raise, diag_held;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, p, s;
  int          n_fail, checked;
  // pin vectors laid out like the words, diagnostic bit n at 32-n
  cdsc_capture u_dut (.*,
    .cs_parity_type1(p[31]), .cs_parity_type2(p[30]), .rdx_parity(p[20]),
    .burst_dmx_parity(p[29]), .dmx_output_dir(p[28]),
    .board_parity_code(p[27:25]), .control_unit_memory_parity(p[24]),
    .ecc_read_uncorrectable(p[23]), .prefetch_board_parity(p[22]),
    .addr_input_parity(p[21]), .register_file_parity(p[19]),
    .register_addr_parity(p[18]), .direct_memory_transfer_parity(p[17]),
    .address_board_unit_parity(p[16]), .c_board_parity(p[15]),
    .memory_data_bus_even_parity(p[14]), .memory_data_bus_odd_parity(p[13]),
    .miss_missing_module(p[12]), .memory_address_bus_parity(p[11]),
    .memory_address_register_incr(p[10]), .mem_addr_bit15_indicator(p[9]),
    .mem_addr_bit16_indicator(p[8]), .miss_ecc_uncorrectable(p[7]),
    .miss_ecc_correctable(p[6]), .cache_index_parity(p[5]),
    .cache_data_odd_parity(p[4]), .cache_data_even_parity(p[3]),
    .cache_cycle_execute(p[2]), .check_immediate(s[31]),
    .machine_check(s[30]), .memory_parity_check(s[29]),
    .missing_module_check(s[28]), .machine_check_code(s[27:25]),
    .control_unit_memory_error(s[24]), .ecc_uncorrectable_flag(s[23]),
    .ecc_correctable_flag(s[22]), .backup_count_invalid(s[21]),
    .pc_backup_count(s[20:18]), .dmx_in_progress(s[17]),
    .io_in_progress(s[16]), .ecc_syndrome(s[15:10]),
    .error_addr_bit15(s[8]), .error_address_invalid(s[7]),
    .uverify_pass(s[6]), .uverify_test(s[5:0]));
  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task finish_test;
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task ck(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // bounded wait for a design flag sampled high at an edge
  task automatic wt(ref logic x);
    int i;
    i = 0;
    do begin
      @(posedge aclk);
      i++;
    end while (x !== 1'b1 && i < 50);
    if (x !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t wait timed out", $time);
      finish_test();
    end
  endtask
  // ready raised a cycle late so the answer must stand
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    wt(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    wt(s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    ck({30'h0, s_axi_rresp}, {30'h0, r});
    if (r == 2'h0) ck(s_axi_rdata, e);
  endtask
  // each write half is released at the edge that sees its own ready
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int   i;
    logic aw_left;
    logic w_left;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    aw_left = 1'b1;
    w_left = 1'b1;
    i = 0;
    while ((aw_left || w_left) && i < 50) begin
      @(posedge aclk);
      i++;
      if (aw_left && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_left = 1'b0;
      end
      if (w_left && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_left = 1'b0;
      end
    end
    if (aw_left || w_left) begin
      n_fail++;
      $display("CHECK FAILED %0t write not taken", $time);
      finish_test();
    end
    wt(s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    ck({30'h0, s_axi_bresp}, 32'h0000_0000);
  endtask
  task automatic cap(input logic [31:0] pv, sv);
    {p, s, check_raise} <= {pv, sv, 1'b1};
    wt(diag_held);
    {p, check_raise} <= 33'h0_0000_0000;
  endtask
  // sparse flags: copied bits follow only their own events
  task t_sparse;
    cap(32'h1a02_562c, 32'hffff_ffff);
    rd(`CDSC_A_CTRL, 32'h0000_0101, 2'h0);
    rd(`CDSC_A_PARITY, 32'h1002_562c, 2'h0);
    rd(`CDSC_A_STATUS, 32'hfeff_fdff, 2'h0);
    @(posedge aclk);
    ck({31'h0, diag_held}, 32'h0000_0000);
  endtask
  // all flags, no memory parity: ecc fields forced clear
  task t_full;
    cap(32'hffff_ffff, 32'hc5ff_ffff);
    wr(`CDSC_A_PARITY, 32'h0000_0000);
    rd(`CDSC_A_PARITY, 32'hffff_fffc, 2'h0);
    rd(`CDSC_A_STATUS, 32'hc43f_00ff, 2'h0);
  endtask
  // release by write, then a check while capture is disabled
  task t_ctrl;
    cap(32'h0000_0000, 32'h0000_0000);
    wr(`CDSC_A_CTRL, 32'h0000_0003);
    ck({31'h0, diag_held}, 32'h0000_0000);
    wr(`CDSC_A_CTRL, 32'h0000_0000);
    check_raise <= 1'b1;
    repeat (8) @(posedge aclk);
    ck({31'h0, diag_held}, 32'h0000_0000);
    wr(`CDSC_A_CTRL, 32'h0000_0001);
    rd(`CDSC_A_CTRL, 32'h0000_0001, 2'h0);
  endtask
  // reset, reset values and unmapped slot, then the scenarios
  initial begin
    {aresetn, check_raise, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb, s_axi_wdata, p, s} = '0;
    {n_fail, checked} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`CDSC_A_CTRL, 32'h0000_0001, 2'h0);
    rd(`CDSC_A_STATUS, 32'h0000_0000, 2'h0);
    rd(12'h00c, 32'h0000_0000, 2'h2);
    t_sparse();
    t_full();
    t_ctrl();
    finish_test();
  end
endmodule
